/* File: design/hdc_port.sv */
// transceiver control port: pins, processor port and ahb-lite registers
`timescale 1ns/10ps
module hdc_port
  import hdc_pkg::*;
#(
  parameter int unsigned TEST_GAP_CYC = HDC_TEST_GAP_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // init pins
  input wire logic power_up_init_n,
  input wire logic soft_init_n,
  // hardware mode pins
  input wire logic back_end_loopback,
  input wire logic isolated_pulse_test,
  // processor port
  input wire logic device_select_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [3:0] reg_select,
  input wire logic [7:0] host_bus_i,
  output logic [7:0] host_bus_o,
  output logic host_bus_oe,
  output logic int_n_o,
  output logic int_n_oe,
  // line state and mode
  input wire logic remote_end,
  input wire logic line_active,
  input wire logic line_activating,
  input wire logic rx_symbol_strobe,
  // data path
  input wire logic rx_data,
  input wire logic receive_frame_pulse,
  input wire logic tx_data_in,
  input wire logic transmit_frame_pulse,
  output logic tx_data_out,
  output logic tx_frame_out,
  output logic tx_sign,
  output logic tx_mag,
  output logic tx_test_strobe,
  output logic start_activation,
  output logic hw_mode,
  output logic interface_clock,
  output logic recovered_baud_clock
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ph_wr;
    logic [31:0] ph_addr;
    logic [1:0] ctrl;
    logic [3:0] irq_st;
    logic [3:0] irq_en;
    logic [15:0][7:0] regs;
    logic [7:0] bus_o;
    logic [7:0] wr_data;
    logic [3:0] wr_addr;
    logic wr_n_prev;
    logic hw_prev;
    logic loop_prev;
    logic tx_data;
    logic tx_frame;
    logic tx_sign;
    logic tx_mag;
    logic tx_strobe;
    logic start_act;
  } hdc_port_s;

  hdc_port_s q;
  hdc_port_s d;

  logic hw_now;
  logic loop_sel;
  logic test_sel;
  logic loop_on;
  logic test_on;
  logic ahb_take;
  logic host_wr_rise;
  logic init_any;
  logic [3:0] status;
  logic [3:0] events;
  logic [31:0] rd_val;
  logic test_pulse;
  logic [7:0] interface_clock_nx;
  logic [7:0] rclk_nx;
  logic interface_clock_load;
  logic rclk_load;
  logic [7:0] rclk_val;

  // mode decode from the processor port strobes
  assign hw_now = !device_select_n && !host_rd_n && !host_wr_n;
  assign loop_sel = hw_now ? back_end_loopback : q.ctrl[HDC_CTRL_LOOP];
  assign test_sel = hw_now ? isolated_pulse_test : q.ctrl[HDC_CTRL_TEST];
  assign init_any = !power_up_init_n || !soft_init_n;

  // loopback only takes effect in active state
  assign loop_on = loop_sel && line_active && !init_any;
  assign test_on = test_sel && !init_any;

  // ahb address phase accepted
  assign ahb_take = hsel && htrans[1] && hready;

  // write strobe rise while selected, not leaving hardware mode
  assign host_wr_rise = !q.wr_n_prev && host_wr_n
    && !device_select_n && !q.hw_prev;

  // live status word
  assign status[HDC_ST_HW] = hw_now;
  assign status[HDC_ST_LOOP] = loop_on;
  assign status[HDC_ST_TEST] = test_on;
  assign status[HDC_ST_ACT] = line_active;

  // interrupt events
  assign events[HDC_EV_HOSTWR] = host_wr_rise;
  assign events[HDC_EV_PULSE] = test_pulse;
  assign events[HDC_EV_LOOP] = loop_on && !q.loop_prev;
  assign events[HDC_EV_HWMODE] = hw_now && !q.hw_prev;

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;

  // processor bus drive: only while read is asserted and selected
  assign host_bus_oe = !device_select_n && !host_rd_n && host_wr_n;
  assign host_bus_o = q.bus_o;

  // open-drain interrupt: pull low or release
  assign int_n_o = 1'b0;
  assign int_n_oe = |(q.irq_st & q.irq_en);

  // registered data path outputs
  assign tx_data_out = q.tx_data;
  assign tx_frame_out = q.tx_frame;
  assign tx_sign = q.tx_sign;
  assign tx_mag = q.tx_mag;
  assign tx_test_strobe = q.tx_strobe;
  assign start_activation = q.start_act;
  assign hw_mode = q.hw_prev;

  // ahb read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr == HDC_A_CTRL)
      rd_val[1:0] = q.ctrl;
    else if (haddr == HDC_A_STATUS)
      rd_val[3:0] = status;
    else if (haddr == HDC_A_IRQ_ST)
      rd_val[3:0] = q.irq_st;
    else if (haddr == HDC_A_IRQ_EN)
      rd_val[3:0] = q.irq_en;
    else if (haddr[31:6] == HDC_A_WIN_HI && haddr[1:0] == 2'h0)
      rd_val[7:0] = q.regs[haddr[5:2]];
  end

  // next state
  always_comb
  begin
    d = q;

    // ahb address phase capture, read data ready for the data phase
    if (hready)
    begin
      d.ph_wr = ahb_take && hwrite;
      d.ph_addr = haddr;
    end
    if (ahb_take && !hwrite)
      d.rdata = rd_val;

    // interrupt status: sticky, set wins over clear
    d.irq_st = q.irq_st;

    // ahb data phase writes
    if (q.ph_wr)
    begin
      if (q.ph_addr == HDC_A_CTRL)
        d.ctrl = hwdata[1:0];
      else if (q.ph_addr == HDC_A_IRQ_EN)
        d.irq_en = hwdata[3:0];
      else if (q.ph_addr == HDC_A_IRQ_CLR)
        d.irq_st = q.irq_st & ~hwdata[3:0];
    end
    d.irq_st = d.irq_st | events;

    // processor port: sample address and data while write is low
    d.wr_n_prev = host_wr_n;
    d.hw_prev = hw_now;
    d.loop_prev = loop_on;
    if (!host_wr_n && !device_select_n && !hw_now)
    begin
      d.wr_data = host_bus_i;
      d.wr_addr = reg_select;
    end
    if (host_wr_rise)
      d.regs[q.wr_addr] = q.wr_data;

    // read data follows the address one cycle later
    d.bus_o = q.regs[reg_select];

    // transmit path: test pulses replace framed traffic
    if (test_on)
    begin
      d.tx_data = 1'b0;
      d.tx_frame = 1'b0;
    end
    else if (loop_on)
    begin
      d.tx_data = rx_data;
      d.tx_frame = receive_frame_pulse;
    end
    else
    begin
      d.tx_data = tx_data_in;
      d.tx_frame = transmit_frame_pulse;
    end

    // test pulse symbol from data and frame inputs
    d.tx_strobe = test_pulse;
    if (test_pulse)
    begin
      d.tx_sign = tx_data_in;
      d.tx_mag = transmit_frame_pulse;
    end

    // remote end may start activation when test is selected
    d.start_act = remote_end && test_on;

    // init pins clear the device state, bus phase kept intact
    if (init_any)
    begin
      d = '0;
      d.ctrl = HDC_CTRL_RST;
      d.irq_en = HDC_IRQ_EN_RST;
      d.ph_wr = hready ? (ahb_take && hwrite) : q.ph_wr;
      d.ph_addr = hready ? haddr : q.ph_addr;
      d.rdata = (ahb_take && !hwrite) ? rd_val : q.rdata;
      d.wr_n_prev = host_wr_n;
      d.hw_prev = hw_now;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.ctrl <= HDC_CTRL_RST;
      q.irq_en <= HDC_IRQ_EN_RST;
      q.wr_n_prev <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // isolated pulse spacing
  hdc_pulse_gen #(
    .GAP_CYC(TEST_GAP_CYC)
  ) u_pulse (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(test_on),
    .pulse(test_pulse)
  );

  // interface clock: remote end locks it to the received symbols, except while activating
  assign interface_clock_load = remote_end && !line_activating
    && rx_symbol_strobe;

  hdc_baud_div u_interface_clock (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(power_up_init_n),
    .load(interface_clock_load),
    .load_val(8'h00),
    .cnt_nx(interface_clock_nx),
    .clk_o(interface_clock)
  );

  // recovered baud clock phase selection
  always_comb
  begin
    rclk_load = 1'b0;
    rclk_val = 8'h00;
    if (remote_end && !line_activating)
    begin
      rclk_load = 1'b1;
      // follow the interface divider, including its reload to zero
      rclk_val = interface_clock_load ? 8'h00 : interface_clock_nx;
    end
    else if (remote_end)
    begin
      rclk_load = rx_symbol_strobe;
      rclk_val = 8'h00;
    end
    // central office: free running, phase fixed since release
  end

  hdc_baud_div u_rclk (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(power_up_init_n && soft_init_n),
    .load(rclk_load),
    .load_val(rclk_val),
    .cnt_nx(rclk_nx),
    .clk_o(recovered_baud_clock)
  );

endmodule : hdc_port

/* File: include/hdc_pkg.sv */
// constants and register map of the transceiver control port
//
// Behaviour
// - Loopback high in active state routes receive data and frame to transmit.
// - Remote end outputs a 392 kHz recovered baud clock aligned to interface_clock.
// - While activating, the recovered baud clock may drift from interface_clock.
// - Central office keeps a fixed arbitrary baud clock phase to interface_clock.
// - Test input high emits isolated pulses about 6 ms apart, no framing.
// - In test mode transmit data gives the sign, frame pulse the magnitude.
// - Remote end in test mode may start its activation sequence.
// - Register data uses an 8-bit two-way bus, device drives on reads.
// - Power-up init low resets all circuits and halts every clock.
// - Soft init low resets internal circuits while interface_clock keeps running.
// - Interrupt is an open-drain low, released otherwise.
// - Select, read and write all low is hardware mode, else software.
package hdc_pkg;

  // clock and timing
  localparam int unsigned HDC_CLK_KHZ = 100000;
  localparam int unsigned HDC_BAUD_KHZ = 392;
  localparam int unsigned HDC_TEST_GAP_MS = 6;
  // baud divider: whole-cycle period, rounded down
  localparam int unsigned HDC_BAUD_DIV = HDC_CLK_KHZ / HDC_BAUD_KHZ;
  localparam int unsigned HDC_TEST_GAP_CYC = HDC_TEST_GAP_MS * HDC_CLK_KHZ;
  localparam logic [7:0] HDC_BAUD_LAST = 8'(HDC_BAUD_DIV - 1);
  localparam logic [7:0] HDC_BAUD_HALF = 8'(HDC_BAUD_DIV / 2);

  // ahb-lite byte addresses
  localparam logic [31:0] HDC_A_CTRL = 32'h0000_0000;
  localparam logic [31:0] HDC_A_STATUS = 32'h0000_0004;
  localparam logic [31:0] HDC_A_IRQ_ST = 32'h0000_0008;
  localparam logic [31:0] HDC_A_IRQ_EN = 32'h0000_000C;
  localparam logic [31:0] HDC_A_IRQ_CLR = 32'h0000_0010;
  localparam logic [25:0] HDC_A_WIN_HI = 26'h000_0001;

  // control fields
  localparam int unsigned HDC_CTRL_LOOP = 0;
  localparam int unsigned HDC_CTRL_TEST = 1;
  localparam logic [1:0] HDC_CTRL_RST = 2'h0;

  // status fields
  localparam int unsigned HDC_ST_HW = 0;
  localparam int unsigned HDC_ST_LOOP = 1;
  localparam int unsigned HDC_ST_TEST = 2;
  localparam int unsigned HDC_ST_ACT = 3;

  // interrupt event bits
  localparam int unsigned HDC_EV_HOSTWR = 0;
  localparam int unsigned HDC_EV_PULSE = 1;
  localparam int unsigned HDC_EV_LOOP = 2;
  localparam int unsigned HDC_EV_HWMODE = 3;
  localparam logic [3:0] HDC_IRQ_EN_RST = 4'h0;

endpackage : hdc_pkg

/* File: design/hdc_baud_div.sv */
// 392 kHz baud divider with phase load
`timescale 1ns/10ps
module hdc_baud_div
  import hdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic [7:0] cnt_nx,
  output logic clk_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic clk;
  } hdc_div_s;

  hdc_div_s q;
  hdc_div_s d;

  // next phase, shared with followers that copy it
  assign cnt_nx = (q.cnt == HDC_BAUD_LAST) ? 8'h00 : q.cnt + 8'h01;
  assign clk_o = q.clk;

  // count, reload or clear to zero
  always_comb
  begin
    d = q;
    if (!run)
    begin
      d.cnt = 8'h00;
    end
    else if (load)
    begin
      d.cnt = load_val;
    end
    else
    begin
      d.cnt = cnt_nx;
    end
    d.clk = run && (d.cnt < HDC_BAUD_HALF);
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

endmodule : hdc_baud_div

/* File: design/hdc_pulse_gen.sv */
// isolated test pulse timer
`timescale 1ns/10ps
module hdc_pulse_gen
  import hdc_pkg::*;
#(
  parameter int unsigned GAP_CYC = HDC_TEST_GAP_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic pulse
);

  typedef struct packed {
    logic [19:0] cnt;
    logic pulse;
  } hdc_pg_s;

  hdc_pg_s q;
  hdc_pg_s d;

  assign pulse = q.pulse;

  // one strobe per gap while running
  always_comb
  begin
    d = q;
    d.pulse = 1'b0;
    if (!run)
    begin
      d.cnt = 20'h0_0000;
    end
    else if (q.cnt == 20'(GAP_CYC - 1))
    begin
      d.cnt = 20'h0_0000;
      d.pulse = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 20'h0_0001;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

endmodule : hdc_pulse_gen

/* File: sim/hdc_port_assertions.sv */
// assertion checker for the transceiver control port
`timescale 1ns/10ps
module hdc_port_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_up_init_n,
  input wire logic soft_init_n,
  input wire logic back_end_loopback,
  input wire logic isolated_pulse_test,
  input wire logic device_select_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_bus_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  input wire logic line_active,
  input wire logic remote_end,
  input wire logic line_activating,
  input wire logic rx_data,
  input wire logic tx_data_in,
  input wire logic transmit_frame_pulse,
  input wire logic tx_data_out,
  input wire logic tx_sign,
  input wire logic tx_mag,
  input wire logic tx_test_strobe,
  input wire logic hw_mode,
  input wire logic interface_clock,
  input wire logic recovered_baud_clock
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic inits_off;
  // both init pins released
  assign inits_off = power_up_init_n && soft_init_n;
  a_hw_enter:
  assert property (inits_off && !device_select_n && !host_rd_n && !host_wr_n
    |=> hw_mode) else $error("hardware mode not entered");
  a_hw_leave:
  assert property (device_select_n |=> !hw_mode)
    else $error("hardware mode kept without select");
  a_bus_drive:
  assert property (!device_select_n && !host_rd_n && host_wr_n |-> host_bus_oe)
    else $error("bus not driven on read");
  a_bus_release:
  assert property (device_select_n || host_rd_n |-> !host_bus_oe)
    else $error("bus not released");
  a_int_pull_low:
  assert property (int_n_oe |-> int_n_o == 1'h0)
    else $error("interrupt not pulled low");
  a_loop_path:
  assert property ((hw_mode && back_end_loopback && line_active && inits_off
    && !device_select_n && !host_rd_n && !host_wr_n
    && !isolated_pulse_test) [*3] |=> tx_data_out == $past(rx_data))
    else $error("loopback data wrong");
  a_baud_align:
  assert property (remote_end && !line_activating && inits_off
    |=> recovered_baud_clock == interface_clock)
    else $error("baud clock not aligned to interface clock");
  a_pulse_symbol:
  assert property (tx_test_strobe |-> tx_sign == $past(tx_data_in)
    && tx_mag == $past(transmit_frame_pulse)) else $error("pulse symbol wrong");
  a_strobe_single:
  assert property (tx_test_strobe |=> !tx_test_strobe)
    else $error("test strobe too long");
  a_power_stop:
  assert property (!power_up_init_n |=> !interface_clock
    && !recovered_baud_clock) else $error("clock runs in power-up init");
  a_soft_stop:
  assert property (!soft_init_n |=> !recovered_baud_clock)
    else $error("baud clock runs in soft init");
endmodule : hdc_port_assertions

bind hdc_port hdc_port_assertions i_hdc_port_assertions (.*);

/* File: sim/hdc_host.sv */
// host processor model driving the processor port
`timescale 1ns/10ps
module hdc_host (
  input wire logic hclk,
  output logic device_select_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [3:0] reg_select,
  output logic [7:0] host_bus_i,
  input wire logic [7:0] host_bus_o,
  input wire logic host_bus_oe
);
  logic drv = 1'h0;
  logic [7:0] dat = 8'h00;
  initial {device_select_n, host_rd_n, host_wr_n, reg_select} = 7'h70;
  // wire level: device, then host, else the pull-ups hold it high
  assign host_bus_i = host_bus_oe ? host_bus_o : drv ? dat : 8'hFF;
  // write: strobe low while selected, value taken on strobe rise
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    device_select_n <= 1'h0;
    host_wr_n <= 1'h0;
    reg_select <= a;
    dat <= d;
    drv <= 1'h1;
    @(posedge hclk);
    host_wr_n <= 1'h1;
    @(posedge hclk);
    device_select_n <= 1'h1;
    drv <= 1'h0;
  endtask : wr
  // read: the device drives the bus while strobe and select are low
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    device_select_n <= 1'h0;
    host_rd_n <= 1'h0;
    reg_select <= a;
    @(posedge hclk);
    @(posedge hclk);
    d = host_bus_i;
    device_select_n <= 1'h1;
    host_rd_n <= 1'h1;
  endtask : rd
  // hardware mode: all three lines low together
  task automatic hw(input logic on);
    {device_select_n, host_rd_n, host_wr_n} <= {3{~on}};
  endtask : hw
endmodule : hdc_host

/* File: sim/tb_hdc_port.sv */
// testbench of the transceiver control port
`timescale 1ns/10ps
module tb_hdc_port;
  import hdc_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic power_up_init_n = 1'h0, soft_init_n = 1'h1, back_end_loopback = 1'h0;
  logic isolated_pulse_test = 1'h0, remote_end = 1'h0, line_active = 1'h1;
  logic line_activating = 1'h0, rx_symbol_strobe = 1'h0, rx_data = 1'h0;
  logic receive_frame_pulse = 1'h1, tx_data_in = 1'h1, tog = 1'h0;
  logic transmit_frame_pulse = 1'h0, hready, hreadyout, hresp, int_n_o;
  logic device_select_n, host_rd_n, host_wr_n, host_bus_oe, int_n_oe;
  logic tx_data_out, tx_frame_out, tx_sign, tx_mag, tx_test_strobe;
  logic start_activation, hw_mode, interface_clock, recovered_baud_clock;
  logic [3:0] reg_select;
  logic [7:0] host_bus_i, host_bus_o, b;
  int num_errors = 0, checked = 0, cyc = 0, gap = 0, ic_n = 0, rb_n = 0;
  assign hready = hreadyout;
  hdc_port #(.TEST_GAP_CYC(20)) i_hdc_port (.*);
  hdc_host i_hdc_host (.*);
  initial forever #5 hclk = ~hclk;
  // receive path toggling, hang limit and clock edge counters
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    rx_symbol_strobe <= (cyc % 97) == 0;
    if (tog)
      {rx_data, receive_frame_pulse} <= ~{rx_data, receive_frame_pulse};
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  always @(posedge interface_clock) ic_n++;
  always @(posedge recovered_baud_clock) rb_n++;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // one single-word transfer; read data is taken at the data-phase edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    r = hrdata;
  endtask : ahb
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0000_0000);
    cmp(r, e);
  endtask : rdc
  task automatic strobe_gap;
    gap = 0;
    do
    begin
      @(posedge hclk);
      gap++;
    end
    while (tx_test_strobe !== 1'h1 && gap < 100);
  endtask : strobe_gap
  task automatic final_report;
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    power_up_init_n <= 1'h1;
    repeat (2) @(posedge hclk);
    // reset values, write-only clear, unmapped place
    rdc(HDC_A_CTRL, 32'h0000_0000);
    rdc(HDC_A_IRQ_EN, 32'h0000_0000);
    rdc(HDC_A_IRQ_CLR, 32'h0000_0000);
    rdc(32'h0000_0020, 32'h0000_0000);
    // processor port at first-used and last register
    i_hdc_host.wr(4'h5, 8'hA5);
    rdc(32'h0000_0054, 32'h0000_00A5);
    i_hdc_host.wr(4'hF, 8'h3C);
    rdc(32'h0000_007C, 32'h0000_003C);
    i_hdc_host.rd(4'h5, b);
    cmp({24'h00_0000, b}, 32'h0000_00A5);
    // interrupt raised, masked, enabled, cleared
    rdc(HDC_A_IRQ_ST, 32'h0000_0001);
    cmp({31'h0, int_n_oe}, 32'h0000_0000);
    ahb(1'h1, HDC_A_IRQ_EN, 32'h0000_0001);
    @(posedge hclk);
    cmp({31'h0, int_n_oe}, 32'h0000_0001);
    ahb(1'h1, HDC_A_IRQ_CLR, 32'h0000_0001);
    @(posedge hclk);
    cmp({31'h0, int_n_oe}, 32'h0000_0000);
    // hardware mode with receive-to-transmit loopback
    back_end_loopback <= 1'h1;
    tog <= 1'h1;
    i_hdc_host.hw(1'h1);
    repeat (4) @(posedge hclk);
    #1;
    cmp({tx_data_out, tx_frame_out}, {30'h0, ~rx_data, ~receive_frame_pulse});
    rdc(HDC_A_STATUS, 32'h0000_000B);
    // isolated test pulses at the remote end
    back_end_loopback <= 1'h0;
    tog <= 1'h0;
    isolated_pulse_test <= 1'h1;
    remote_end <= 1'h1;
    repeat (2) strobe_gap();
    cmp(gap, 32'h0000_0014);
    cmp({tx_sign, tx_mag}, 32'h0000_0002);
    cmp({31'h0, start_activation}, 32'h0000_0001);
    isolated_pulse_test <= 1'h0;
    remote_end <= 1'h0;
    i_hdc_host.hw(1'h0);
    repeat (2) @(posedge hclk);
    cmp({31'h0, hw_mode}, 32'h0000_0000);
    // soft init, then power-up init
    soft_init_n <= 1'h0;
    @(posedge hclk);
    ic_n = 0;
    rb_n = 0;
    repeat (600) @(posedge hclk);
    cmp({31'h0, ic_n != 0}, 32'h0000_0001);
    cmp(rb_n, 32'h0000_0000);
    soft_init_n <= 1'h1;
    power_up_init_n <= 1'h0;
    @(posedge hclk);
    ic_n = 0;
    rb_n = 0;
    repeat (600) @(posedge hclk);
    cmp(ic_n + rb_n, 32'h0000_0000);
    final_report();
  end
endmodule : tb_hdc_port
